// File: include/lmfsc_pkg.sv
`default_nettype none
// ============================================================
// Shared constants for the font and scan control block
package lmfsc_pkg;

	// ========================================================
	// Register indices of the command port (low seven bits)
	localparam logic [6:0] REG_NOOP       = 7'h00;
	localparam logic [6:0] REG_INTENS_LOW = 7'h01;
	localparam logic [6:0] REG_INTENS_HI  = 7'h02;
	localparam logic [6:0] REG_DIGIT_CNT  = 7'h03;
	localparam logic [6:0] REG_CONFIG     = 7'h04;
	localparam logic [6:0] REG_GLYPH_PORT = 7'h05;
	localparam logic [6:0] REG_DISP_TEST  = 7'h07;

	// Command address bit that marks a read
	localparam int CMD_READ_BIT = 7;

	// ========================================================
	// Configuration register field positions
	localparam int CFG_RUN_BIT   = 0;  // 1 = normal, 0 = shutdown
	localparam int CFG_FAST_BIT  = 2;  // Blink rate select
	localparam int CFG_BLINK_BIT = 3;  // Global blink enable
	localparam int CFG_PHASE_BIT = 7;  // Blink phase readback
	localparam int TEST_EN_BIT   = 0;  // Display test enable
	localparam int SCAN_ALL_BIT  = 0;  // Four digit scan

	// ========================================================
	// Glyph pointer range and storage size
	localparam logic [7:0] PTR_FIRST    = 8'h80;
	localparam logic [7:0] PTR_LAST     = 8'hF7;
	localparam int         FONT_ENTRIES = 120;
	localparam int         GLYPH_BITS   = 7;

	// ========================================================
	// Reset values
	localparam logic [7:0] INTENS_RESET = 8'h00;

	// ========================================================
	// Multiplex timing, counted in multiplex clock edges
	localparam int OSC_REF_HZ     = 4000000;
	localparam int SLOW_PLANE_MS  = 1000;
	localparam int FAST_PLANE_MS  = 500;
	localparam int SCAN_DIVIDER   = 5600;
	localparam int SLOT_WIDTH     = 13;
	localparam int BLINK_WIDTH    = 23;
	localparam int SLOTS_PAIR     = 1;   // Digits 0 and 1 only
	localparam int SLOTS_ALL      = 2;   // Two pair slots
	localparam int SLOTS_TEST     = 8;   // Test mode slots
	localparam logic [4:0] TEST_DUTY = 5'h07;
	localparam logic [4:0] MAX_DUTY  = 5'h0F;
	localparam int DUTY_SHIFT     = 4;   // Sixteen steps per slot

endpackage : lmfsc_pkg
`default_nettype wire

// File: include/lmfsc_scan_if.sv
`default_nettype none
// ============================================================
// Scan timing shared by the slot sequencer and each modulator
interface lmfsc_scan_if;
	logic [lmfsc_pkg::SLOT_WIDTH-1:0] slotPos;   // Tick within slot
	logic [lmfsc_pkg::SLOT_WIDTH-1:0] slotLen;   // Ticks per slot
	logic                             testMode;  // Fixed duty

	// Sequencer side
	modport src (
		output slotPos,
		output slotLen,
		output testMode
	);

	// Modulator side
	modport pwm (
		input slotPos,
		input slotLen,
		input testMode
	);
endinterface : lmfsc_scan_if
`default_nettype wire

// File: logic/lmfsc_digit_pwm.sv
`default_nettype none
// ============================================================
// One digit's sixteen step pulse width modulator
module lmfsc_digit_pwm (
	// Shared scan timing
	lmfsc_scan_if.pwm        scan,
	// Per digit control
	input wire logic [3:0]   intensity,
	input wire logic         selected,
	// Result
	output logic             lit
);
	// ========================================================
	// Duty in sixteenths
	logic [4:0]  duty;       // On sixteenths of the slot
	logic [21:0] posScaled;  // Slot position times sixteen
	logic [21:0] onLimit;    // Duty times slot length

	// Top code repeats the one below, so a blank sixteenth stays
	always_comb begin
		if (scan.testMode) begin
			duty = lmfsc_pkg::TEST_DUTY;
		end else if (intensity == 4'hF) begin
			duty = lmfsc_pkg::MAX_DUTY;
		end else begin
			duty = 5'({1'b0, intensity} + 5'h01);
		end
	end

	// Compare without division: pos*16 < duty*len
	always_comb begin
		posScaled = 22'({scan.slotPos, 4'h0});
		onLimit   = 22'(duty * scan.slotLen);
		lit       = selected && (posScaled < onLimit);
	end
endmodule : lmfsc_digit_pwm
`default_nettype wire

// File: logic/lmfsc_control.sv
`default_nettype none
// ============================================================
// Font memory, register file, scan sequencer and blink timer
module lmfsc_control #(
	parameter int FRAME_TICKS = lmfsc_pkg::SCAN_DIVIDER,
	parameter int SLOW_TICKS  =
		lmfsc_pkg::OSC_REF_HZ / 1000 * lmfsc_pkg::SLOW_PLANE_MS,
	parameter int FAST_TICKS  =
		lmfsc_pkg::OSC_REF_HZ / 1000 * lmfsc_pkg::FAST_PLANE_MS
) (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         rst,
	// Multiplex clock pin, sampled level
	input wire logic         multiplexClockPin,
	// Register command port
	input wire logic         cmdStrobe,
	input wire logic [7:0]   cmdAddr,
	input wire logic [7:0]   cmdData,
	output logic [7:0]       rdData,
	output logic             rdValid,
	// Display side
	output logic [3:0]       digitDrive,
	output logic             allLedsOn,
	output logic             alternatePlaneSel,
	output logic             blinkOut
);
	// ========================================================
	// Derived slot lengths for the three scan shapes
	localparam int SLOT_PAIR_LEN = FRAME_TICKS / lmfsc_pkg::SLOTS_PAIR;
	localparam int SLOT_ALL_LEN  = FRAME_TICKS / lmfsc_pkg::SLOTS_ALL;
	localparam int SLOT_TEST_LEN = FRAME_TICKS / lmfsc_pkg::SLOTS_TEST;
	localparam logic [2:0] MASK_PAIR = 3'(lmfsc_pkg::SLOTS_PAIR - 1);
	localparam logic [2:0] MASK_ALL  = 3'(lmfsc_pkg::SLOTS_ALL - 1);
	localparam logic [2:0] MASK_TEST = 3'(lmfsc_pkg::SLOTS_TEST - 1);
	localparam logic [lmfsc_pkg::BLINK_WIDTH-1:0] SLOW_LAST =
		lmfsc_pkg::BLINK_WIDTH'(SLOW_TICKS - 1);
	localparam logic [lmfsc_pkg::BLINK_WIDTH-1:0] FAST_LAST =
		lmfsc_pkg::BLINK_WIDTH'(FAST_TICKS - 1);

	// ========================================================
	// Whole state of the block
	typedef struct packed {
		logic [lmfsc_pkg::FONT_ENTRIES-1:0]
			[lmfsc_pkg::GLYPH_BITS-1:0]    font;       // Glyph memory
		logic [7:0]                        glyphPtr;   // Font pointer
		logic [7:0]                        intensLow;  // Digits 0,1
		logic [7:0]                        intensHigh; // Digits 2,3
		logic                              scanAll;    // Four digits
		logic                              runMode;    // Not shutdown
		logic                              blinkEn;    // Blink enable
		logic                              blinkFast;  // Rate select
		logic                              testMode;   // Display test
		logic                              oscPrev;    // Pin history
		logic [lmfsc_pkg::SLOT_WIDTH-1:0]  slotPos;    // Tick in slot
		logic [2:0]                        slotIdx;    // Slot number
		logic [lmfsc_pkg::BLINK_WIDTH-1:0] blinkCnt;   // Plane timer
		logic                              primary;    // Blink phase
		logic [3:0]                        digitDrive; // Lit digits
		logic [7:0]                        rdData;     // Read answer
		logic                              rdValid;    // Answer flag
	} lmfsc_state_t;

	lmfsc_state_t st_reg;   // Registered state
	lmfsc_state_t st_next;  // Next state

	// ========================================================
	// Shared scan timing and the four modulators
	lmfsc_scan_if scan ();

	logic [3:0] pairSelect;  // Digits scanned in the present slot
	logic [3:0] digitLit;    // Modulator outputs
	logic [3:0] intensNib [4];
	logic [lmfsc_pkg::SLOT_WIDTH-1:0] slotLen;
	logic [2:0] slotMask;

	// Test mode ignores the stored scan limit and shutdown
	always_comb begin
		if (st_reg.testMode) begin
			slotLen  = lmfsc_pkg::SLOT_WIDTH'(SLOT_TEST_LEN);
			slotMask = MASK_TEST;
		end else if (st_reg.scanAll) begin
			slotLen  = lmfsc_pkg::SLOT_WIDTH'(SLOT_ALL_LEN);
			slotMask = MASK_ALL;
		end else begin
			slotLen  = lmfsc_pkg::SLOT_WIDTH'(SLOT_PAIR_LEN);
			slotMask = MASK_PAIR;
		end
	end

	assign scan.slotPos  = st_reg.slotPos;
	assign scan.slotLen  = slotLen;
	assign scan.testMode = st_reg.testMode;

	// Odd slots drive the upper pair, even slots the lower one; shutdown outside test mode drives neither
	always_comb begin
		if (st_reg.testMode) begin
			// Registers keep their contents, only the view changes
			pairSelect = st_reg.slotIdx[0] ? 4'hC : 4'h3;
		end else if (!st_reg.runMode) begin
			pairSelect = 4'h0;
		end else if (st_reg.scanAll && st_reg.slotIdx[0]) begin
			pairSelect = 4'hC;
		end else begin
			pairSelect = 4'h3;
		end
	end

	// Nibble per digit
	assign intensNib[0] = st_reg.intensLow[3:0];
	assign intensNib[1] = st_reg.intensLow[7:4];
	assign intensNib[2] = st_reg.intensHigh[3:0];
	assign intensNib[3] = st_reg.intensHigh[7:4];

	// One independent modulator for each digit
	genvar d;
	generate
		for (d = 0; d < 4; d++) begin : g_pwm
			lmfsc_digit_pwm u_pwm (
				.scan      (scan),
				.intensity (intensNib[d]),
				.selected  (pairSelect[d]),
				.lit       (digitLit[d])
			);
		end
	endgenerate

	// ========================================================
	// Glyph pointer helpers
	function automatic logic [7:0] ptr_advance(input logic [7:0] p);
		if (p == lmfsc_pkg::PTR_LAST) begin
			ptr_advance = lmfsc_pkg::PTR_FIRST;
		end else begin
			ptr_advance = 8'(p + 8'h01);
		end
	endfunction : ptr_advance

	// Out of range loads fall back to the first entry
	function automatic logic [7:0] ptr_load(input logic [7:0] v);
		if (v > lmfsc_pkg::PTR_LAST) begin
			ptr_load = lmfsc_pkg::PTR_FIRST;
		end else begin
			ptr_load = v;
		end
	endfunction : ptr_load

	// ========================================================
	// Next state: commands, scan sequencer and blink timer
	logic        oscTick;    // Rising edge of the multiplex clock
	logic [6:0]  fontIdx;    // Memory index of the pointer
	logic [6:0]  regIdx;     // Register addressed by the command
	logic        isRead;     // Command reads
	logic [lmfsc_pkg::BLINK_WIDTH-1:0] blinkLast;

	always_comb begin
		st_next = st_reg;
		// The pin is taken as synchronous, so a plain edge detect
		oscTick = multiplexClockPin && !st_reg.oscPrev;
		// Pointer never leaves 0x80..0xF7, so bit seven is the base
		fontIdx = st_reg.glyphPtr[6:0];
		regIdx  = cmdAddr[6:0];
		isRead  = cmdAddr[lmfsc_pkg::CMD_READ_BIT];
		blinkLast = st_reg.blinkFast ? FAST_LAST : SLOW_LAST;
		st_next.oscPrev = multiplexClockPin;
		st_next.rdValid = 1'b0;

		// Register command
		if (cmdStrobe && isRead) begin
			st_next.rdValid = 1'b1;
			st_next.rdData  = 8'h00;
			unique case (regIdx)
				lmfsc_pkg::REG_INTENS_LOW: begin
					st_next.rdData = st_reg.intensLow;
				end
				lmfsc_pkg::REG_INTENS_HI: begin
					st_next.rdData = st_reg.intensHigh;
				end
				lmfsc_pkg::REG_DIGIT_CNT: begin
					st_next.rdData[lmfsc_pkg::SCAN_ALL_BIT] =
						st_reg.scanAll;
				end
				lmfsc_pkg::REG_CONFIG: begin
					// Phase shows the blink pin level right now
					st_next.rdData[lmfsc_pkg::CFG_PHASE_BIT] =
						st_reg.primary;
					st_next.rdData[lmfsc_pkg::CFG_BLINK_BIT] =
						st_reg.blinkEn;
					st_next.rdData[lmfsc_pkg::CFG_FAST_BIT] =
						st_reg.blinkFast;
					st_next.rdData[lmfsc_pkg::CFG_RUN_BIT] =
						st_reg.runMode;
				end
				lmfsc_pkg::REG_GLYPH_PORT: begin
					st_next.rdData   = {1'b0, st_reg.font[fontIdx]};
					st_next.glyphPtr = ptr_advance(st_reg.glyphPtr);
				end
				lmfsc_pkg::REG_DISP_TEST: begin
					st_next.rdData[lmfsc_pkg::TEST_EN_BIT] =
						st_reg.testMode;
				end
				default: begin
					// Unmapped and no-op reads answer zero
					st_next.rdData = 8'h00;
				end
			endcase
		end else if (cmdStrobe) begin
			unique case (regIdx)
				lmfsc_pkg::REG_INTENS_LOW: begin
					st_next.intensLow = cmdData;
				end
				lmfsc_pkg::REG_INTENS_HI: begin
					st_next.intensHigh = cmdData;
				end
				lmfsc_pkg::REG_DIGIT_CNT: begin
					// Upper bits are dropped; a change while running
					// only shifts the slot pattern for one frame
					st_next.scanAll =
						cmdData[lmfsc_pkg::SCAN_ALL_BIT];
				end
				lmfsc_pkg::REG_CONFIG: begin
					st_next.runMode =
						cmdData[lmfsc_pkg::CFG_RUN_BIT];
					st_next.blinkFast =
						cmdData[lmfsc_pkg::CFG_FAST_BIT];
					st_next.blinkEn =
						cmdData[lmfsc_pkg::CFG_BLINK_BIT];
				end
				lmfsc_pkg::REG_GLYPH_PORT: begin
					if (cmdData[7]) begin
						st_next.glyphPtr = ptr_load(cmdData);
					end else begin
						st_next.font[fontIdx] = cmdData[6:0];
						st_next.glyphPtr =
							ptr_advance(st_reg.glyphPtr);
					end
				end
				lmfsc_pkg::REG_DISP_TEST: begin
					st_next.testMode =
						cmdData[lmfsc_pkg::TEST_EN_BIT];
				end
				default: begin
					// No-op and unmapped writes leave state alone
					st_next.rdData = st_reg.rdData;
				end
			endcase
		end

		// Slot sequencer, one step per multiplex clock edge
		if (oscTick) begin
			if (st_reg.slotPos >= slotLen - 1'b1) begin
				st_next.slotPos = '0;
				// Frame of all slots spans the full divider
				st_next.slotIdx = 3'(st_reg.slotIdx + 3'h1)
					& slotMask;
			end else begin
				st_next.slotPos =
					lmfsc_pkg::SLOT_WIDTH'(st_reg.slotPos + 1'b1);
			end
			// Plane timer; a shorter rate ends the plane at once
			if (st_reg.blinkCnt >= blinkLast) begin
				st_next.blinkCnt = '0;
				st_next.primary  = !st_reg.primary;
			end else begin
				st_next.blinkCnt =
					lmfsc_pkg::BLINK_WIDTH'(st_reg.blinkCnt + 1'b1);
			end
		end

		// Slot index may exceed a narrower mask after a mode change
		st_next.slotIdx = st_next.slotIdx & slotMask;
		st_next.digitDrive = digitLit;
	end

	// ========================================================
	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg            <= '0;
			st_reg.glyphPtr   <= lmfsc_pkg::PTR_FIRST;
			st_reg.intensLow  <= lmfsc_pkg::INTENS_RESET;
			st_reg.intensHigh <= lmfsc_pkg::INTENS_RESET;
			st_reg.scanAll    <= 1'b0;
			st_reg.runMode    <= 1'b0;
			st_reg.primary    <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ========================================================
	// Outputs from flip-flops; alternatePlaneSel is gated from two of them
	assign rdData     = st_reg.rdData;
	assign rdValid    = st_reg.rdValid;
	assign digitDrive = st_reg.digitDrive;
	assign allLedsOn  = st_reg.testMode;
	assign blinkOut   = st_reg.primary;
	// Without blink only the primary plane is shown
	assign alternatePlaneSel = st_reg.blinkEn && !st_reg.primary;
endmodule : lmfsc_control
`default_nettype wire

// File: bench/lmfsc_control_asserts.sv
`default_nettype none
// ============================================================
// Port level checker for the font and scan control block
module lmfsc_control_asserts (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Register command port
	input wire logic       cmdStrobe,
	input wire logic [7:0] cmdAddr,
	input wire logic [7:0] rdData,
	input wire logic       rdValid,
	// Display side
	input wire logic [3:0] digitDrive,
	input wire logic       allLedsOn,
	input wire logic       alternatePlaneSel,
	input wire logic       blinkOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ========================================================
	// Command port answers
	a_read_answer: assert property (
		cmdStrobe && cmdAddr[7] |=> rdValid) else $error("read unanswered");
	a_stray_valid: assert property (
		!(cmdStrobe && cmdAddr[7]) |=> !rdValid) else $error("stray valid");
	a_glyph_msb: assert property (
		cmdStrobe && cmdAddr == 8'h85 |=> !rdData[7]) else $error("glyph msb");
	// Phase may be read from the register one stage behind the pin
	a_phase_read: assert property (
		cmdStrobe && cmdAddr == 8'h84 |=>
		rdData[7] == $past(blinkOut) || rdData[7] == blinkOut)
		else $error("phase readback");
	a_noop_read: assert property (
		cmdStrobe && cmdAddr == 8'h80 |=> rdData == 8'h00) else $error("noop");
	a_data_holds: assert property (
		!rdValid |-> $stable(rdData)) else $error("read data moved");

	// ========================================================
	// Display side
	a_pairs_apart: assert property (
		!(|digitDrive[1:0] && |digitDrive[3:2])) else $error("pairs overlap");
	// Two settled cycles skip the output register's lag on entry
	a_test_pairs: assert property (
		$past(allLedsOn, 2) && allLedsOn |->
		digitDrive inside {4'h0, 4'h3, 4'hC}) else $error("test pattern");
	a_alt_phase: assert property (
		alternatePlaneSel |-> !blinkOut) else $error("plane vs phase");
	a_blink_hold: assert property (
		$changed(blinkOut) |=> $stable(blinkOut)[*8]) else $error("blink");

	// Main scenarios
	c_read: cover property (rdValid && cmdAddr != 8'h85);
	c_fall: cover property ($fell(blinkOut));
	c_test: cover property (allLedsOn);
endmodule : lmfsc_control_asserts

bind lmfsc_control lmfsc_control_asserts u_lmfsc_control_asserts (
	.mclk, .rst, .cmdStrobe, .cmdAddr, .rdData, .rdValid,
	.digitDrive, .allLedsOn, .alternatePlaneSel, .blinkOut
);
`default_nettype wire

// File: bench/lmfsc_host_model.sv
`default_nettype none
// ============================================================
// Host processor and oscillator on the far side of the port
module lmfsc_host_model (
	// Clock
	input wire logic       mclk,
	// Answers from the block
	input wire logic [7:0] rdData,
	input wire logic       rdValid,
	// Commands and multiplex clock
	output var logic       cmdStrobe,
	output var logic [7:0] cmdAddr,
	output var logic [7:0] cmdData,
	output var logic       multiplexClockPin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] oscDiv; // Tick every four mclk, below half rate

	initial begin
		cmdStrobe = 1'b0;
		cmdAddr = 8'h00;
		cmdData = 8'h00;
		oscDiv = 2'h0;
		multiplexClockPin = 1'b0;
	end

	// Free running oscillator
	always @(posedge mclk) begin
		oscDiv <= oscDiv + 2'h1;
		multiplexClockPin <= oscDiv[1];
	end

	// One command; bit seven of the address marks a read
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		@(posedge mclk);
		#1;
		cmdStrobe = 1'b1;
		cmdAddr = a;
		cmdData = d;
		@(posedge mclk);
		#1;
		// The answer stands only in the cycle after the taking edge
		q = rdData;
		ok = rdValid;
		// Released lines show garbage, not the last value
		cmdStrobe = 1'b0;
		cmdAddr = ~a;
		cmdData = ~d;
	endtask : xfer
endmodule : lmfsc_host_model
`default_nettype wire

// File: bench/lmfsc_control_test.sv
`default_nettype none
// ============================================================
// Self checking bench for the font and scan control block
module lmfsc_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FRAME = 128; // Short frame, multiple of 128
	localparam int SLOW  = 64;
	localparam int FAST  = 32;
	logic       mclk, rst, cmdStrobe, multiplexClockPin, rdValid;
	logic       allLedsOn, alternatePlaneSel, blinkOut, ok;
	logic [7:0] cmdAddr, cmdData, rdData, got;
	logic [3:0] digitDrive;
	logic [7:0] glyph [5] = '{8'h42, 8'h61, 8'h7F, 8'h49, 8'h00};
	int         n_fail, total_checks, cyc, sl, m;

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	lmfsc_control #(.FRAME_TICKS(FRAME), .SLOW_TICKS(SLOW),
		.FAST_TICKS(FAST)) u_lmfsc_control (
		.mclk(mclk), .rst(rst), .multiplexClockPin(multiplexClockPin),
		.cmdStrobe(cmdStrobe), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.rdData(rdData), .rdValid(rdValid), .digitDrive(digitDrive),
		.allLedsOn(allLedsOn), .alternatePlaneSel(alternatePlaneSel),
		.blinkOut(blinkOut));

	lmfsc_host_model u_lmfsc_host_model (
		.mclk(mclk), .rdData(rdData), .rdValid(rdValid),
		.cmdStrobe(cmdStrobe), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.multiplexClockPin(multiplexClockPin));

	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Writes never answer, reads always answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_lmfsc_host_model.xfer(a, d, got, ok);
		chk(16'(ok), 16'h0000);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_lmfsc_host_model.xfer(a, 8'h00, got, ok);
		chk(16'(ok), 16'h0001);
		chk(16'(got), 16'(e));
	endtask : rdc

	// Lit mclk cycles per frame for code n and slot length in ticks
	function automatic int on(input int n, input int slot);
		return (n < 15 ? n + 1 : 15) * slot / 16 * 4;
	endfunction : on

	// Count lit cycles per digit over one whole frame
	task automatic measure(input int e0, e1, e2, e3);
		int cnt[4];
		cnt = '{0, 0, 0, 0};
		repeat (4) @(posedge mclk);
		for (int i = 0; i < FRAME * 4; i++) begin
			@(posedge mclk);
			#1;
			for (int d = 0; d < 4; d++) begin
				if (digitDrive[d] === 1'b1) cnt[d]++;
			end
		end
		chk(16'(cnt[0]), 16'(e0));
		chk(16'(cnt[1]), 16'(e1));
		chk(16'(cnt[2]), 16'(e2));
		chk(16'(cnt[3]), 16'(e3));
	endtask : measure

	// Cycles until the blink output changes, bounded
	task automatic wait_edge(output int n);
		logic last;
		last = blinkOut;
		n = 0;
		while (blinkOut === last) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 1200) begin
				n_fail++;
				$display("[ERR] %0t blink edge missing", $time);
				final_report();
			end
		end
	endtask : wait_edge

	// Hang guard
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		$display("[ERR] %0t run limit", $time);
		final_report();
	end

	initial begin
		rst = 1'b1;
		n_fail = 0;
		total_checks = 0;
		repeat (12) @(posedge mclk);
		#1;
		rst = 1'b0;
		// Reset values
		chk(16'(digitDrive), 16'h0000);
		rdc(8'h81, 8'h00);
		rdc(8'h82, 8'h00);
		rdc(8'h83, 8'h00);
		rdc(8'h84, 8'h80);
		rdc(8'h85, 8'h00);
		$display("reset test done");
		// Glyph stream at a base, then read back
		wr(8'h05, 8'h8A);
		foreach (glyph[i]) wr(8'h05, glyph[i]);
		wr(8'h05, 8'h8A);
		foreach (glyph[i]) rdc(8'h85, glyph[i]);
		rdc(8'h85, 8'h00);
		$display("glyph test done");
		// Wrap at the last entry and out of range loads
		wr(8'h05, 8'h80);
		wr(8'h05, 8'h2A);
		wr(8'h05, 8'hF7);
		wr(8'h05, 8'h55);
		rdc(8'h85, 8'h2A);
		wr(8'h05, 8'hF9);
		rdc(8'h85, 8'h2A);
		wr(8'h05, 8'hF7);
		rdc(8'h85, 8'h55);
		rdc(8'h85, 8'h2A);
		$display("wrap test done");
		// Intensities and a no-op write in mid stream
		wr(8'h01, 8'hF0);
		wr(8'h02, 8'h73);
		wr(8'h05, 8'h80);
		wr(8'h00, 8'hFF);
		rdc(8'h85, 8'h2A);
		rdc(8'h81, 8'hF0);
		rdc(8'h82, 8'h73);
		$display("register test done");
		// Duty per digit in both widths, limit changed in shutdown
		for (m = 0; m < 2; m++) begin
			sl = m ? FRAME / 2 : FRAME;
			wr(8'h04, 8'h00);
			wr(8'h03, m ? 8'hFF : 8'hFE);
			wr(8'h04, 8'h01);
			measure(on(0, sl), on(15, sl), m ? on(3, sl) : 0,
				m ? on(7, sl) : 0);
		end
		// Display test over shutdown, settings kept
		wr(8'h04, 8'h00);
		wr(8'h07, 8'h01);
		chk(16'(allLedsOn), 16'h0001);
		measure(112, 112, 112, 112);
		wr(8'h07, 8'h00);
		rdc(8'h81, 8'hF0);
		measure(0, 0, 0, 0);
		$display("scan test done");
		// Blink periods, plane select and phase readback
		for (m = 0; m < 2; m++) begin
			wr(8'h04, m ? 8'h0D : 8'h09);
			wait_edge(cyc);
			wait_edge(cyc);
			chk(16'(cyc), 16'((m ? FAST : SLOW) * 4));
			chk(16'(alternatePlaneSel), 16'(!blinkOut));
			// Host acts right after a blink edge, as an interrupt would
			u_lmfsc_host_model.xfer(8'h84, 8'h00, got, ok);
			chk(16'(got), 16'({blinkOut, 3'h0, m ? 4'hD : 4'h9}));
		end
		$display("blink test done");
		final_report();
	end
endmodule : lmfsc_control_test
`default_nettype wire
